// ==== design/analog_and_pin_function_regs.sv ====
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Functional notes
// RL1: Bandwidth codes 00/01/10/11 = 100/80/120/175 kHz
// RL2: Software picks bandwidth to suit switching rate
// RL3: Phase bit 0 out of phase, 1 in
// RL4: Gain code steps attenuation by 0.5 dB
// RL5: Supply reading read-only, 0.12 V per count
// RL6: Direction bit 2 sets pin 2 output
// RL7: Direction bit 1 sets pin 1 output
// RL8: Direction bit 0 sets pin 0 output
// RL9: Pin 0 codes 1000 warning, 1011 fault
// RL10: Pin 0 codes 1100 drop, 1101 data, 1110 ramp
// RL11: Pin 1 codes 1000 warning, 1011 fault
// RL12: Pin 1 codes 1100 undervoltage, 1101 data, 1110 ramp
// RL13: Pin 2 codes 1000 warning, 1011 fault
// RL14: Pin 2 codes 1100 drop, 1101 data, 1110 ramp
// RL15: Code 0000 drives low; others reserved
// RL16: Functions drive pins only in output direction
module analog_and_pin_function_regs
    import amp_ctrl_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Analog side
    input  wire logic [7:0]        supplyVoltageReading,
    output analog_cfg_t            analogCfg,
    output logic [7:0]             loopBandwidthKhz,
    output logic [7:0]             attenHalfDb,
    // Pin function sources and pins
    input  wire pin_src_t          pinSrc,
    input  wire logic [2:0]        pinIn,
    output logic [2:0]             pinOut,
    output logic [2:0]             pinOe
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] loopCtrl_reg;
    logic [7:0] gainCtrl_reg;
    logic [7:0] dirCtrl_reg;
    logic [7:0] func_reg [NUM_PINS];
    logic [7:0] supplyRpt_reg;

    // ----------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ----------------------------------------------------------------
    logic              awHeld_reg;
    logic              wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [31:0]       wData_reg;
    logic [3:0]        wStrb_reg;
    logic              doWrite;
    logic [7:0]        wrIdx;
    logic              wrHit;

    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
    assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrIdx         = awAddr_reg[ADDR_W-1:2];

    // Capture each channel when it is accepted
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= '0;
            wData_reg  <= '0;
            wStrb_reg  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    // Address decode; the read-only report counts as mapped
    always_comb begin
        unique case (wrIdx)
            IDX_ANALOG_LOOP, IDX_ANALOG_GAIN, IDX_SUPPLY_RPT,
            IDX_PIN_DIR, IDX_PIN0_FUNC, IDX_PIN1_FUNC,
            IDX_PIN2_FUNC: wrHit = 1'b1;
            default:       wrHit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register updates; only byte lane 0 carries data, reserved bits
    // are masked so they always read back zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            loopCtrl_reg <= RST_BYTE;
            gainCtrl_reg <= RST_BYTE;
            dirCtrl_reg  <= RST_BYTE;
            for (int i = 0; i < NUM_PINS; i++) begin
                func_reg[i] <= RST_BYTE;
            end
        end else if (doWrite && wStrb_reg[0]) begin
            unique case (wrIdx)
                IDX_ANALOG_LOOP:
                    loopCtrl_reg <= wData_reg[7:0] & LOOP_MASK; // [RL1] [RL3]
                IDX_ANALOG_GAIN:
                    gainCtrl_reg <= wData_reg[7:0] & GAIN_MASK; // [RL4]
                IDX_PIN_DIR:
                    dirCtrl_reg  <= wData_reg[7:0] & DIR_MASK;
                IDX_PIN0_FUNC:
                    func_reg[0]  <= wData_reg[7:0] & FUNC_MASK;
                IDX_PIN1_FUNC:
                    func_reg[1]  <= wData_reg[7:0] & FUNC_MASK;
                IDX_PIN2_FUNC:
                    func_reg[2]  <= wData_reg[7:0] & FUNC_MASK;
                default: ;
            endcase
        end
    end

    // Supply reading sampled every cycle; software writes never land
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            supplyRpt_reg <= RST_BYTE;
        end else begin
            supplyRpt_reg <= supplyVoltageReading;       // [RL5]
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    logic [7:0] rdIdx;
    logic [7:0] rdByte;
    logic       rdHit;

    assign s_axi_arready = !s_axi_rvalid;
    assign rdIdx         = s_axi_araddr[ADDR_W-1:2];

    // Read mux
    always_comb begin
        rdHit = 1'b1;
        unique case (rdIdx)
            IDX_ANALOG_LOOP: rdByte = loopCtrl_reg;
            IDX_ANALOG_GAIN: rdByte = gainCtrl_reg;
            IDX_SUPPLY_RPT:  rdByte = supplyRpt_reg;     // [RL5]
            IDX_PIN_DIR:     rdByte = dirCtrl_reg;
            IDX_PIN0_FUNC:   rdByte = func_reg[0];
            IDX_PIN1_FUNC:   rdByte = func_reg[1];
            IDX_PIN2_FUNC:   rdByte = func_reg[2];
            default: begin
                rdByte = 8'h00;
                rdHit  = 1'b0;
            end
        endcase
    end

    // Read data held until the master takes it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Analog control outputs
    // ----------------------------------------------------------------
    assign analogCfg.loopBandwidthSel  = loopCtrl_reg[BW_LSB +: 2]; // [RL1]
    assign analogCfg.channelPhaseSel   = loopCtrl_reg[PHASE_BIT];   // [RL3]
    assign analogCfg.analogAttenuation = gainCtrl_reg[4:0];         // [RL4]

    analog_decode u_analog_decode (
        .loopBandwidthSel  (analogCfg.loopBandwidthSel),
        .analogAttenuation (analogCfg.analogAttenuation),
        .loopBandwidthKhz  (loopBandwidthKhz),
        .attenHalfDb       (attenHalfDb)
    );

    // ----------------------------------------------------------------
    // Pin function muxes; pin 1 routes undervoltage in place of drop
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        pin_func_mux #(
            .USE_UV (p == 1)
        ) u_mux (
            .sys_clk      (sys_clk),
            .rst_n        (rst_n),
            .outputEnable (dirCtrl_reg[p]),              // [RL6] [RL7] [RL8]
            .pinFunction  (func_reg[p][3:0]),
            .src          (pinSrc),
            .pinOut       (pinOut[p]),
            .pinOe        (pinOe[p])
        );
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_dir_pin2: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pinOe[2] == $past(dirCtrl_reg[2]))               // [RL6]
        else $error("pin 2 direction mismatch");

    a_dir_pin1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pinOe[1] == $past(dirCtrl_reg[1]))               // [RL7]
        else $error("pin 1 direction mismatch");

    a_dir_pin0: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pinOe[0] == $past(dirCtrl_reg[0]))               // [RL8]
        else $error("pin 0 direction mismatch");

    a_phase_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        doWrite && wStrb_reg[0] && wrIdx == IDX_ANALOG_LOOP
        |=> analogCfg.channelPhaseSel == $past(wData_reg[0])) // [RL3]
        else $error("phase bit not applied");

    a_bw_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        analogCfg.loopBandwidthSel == 2'b11 |-> loopBandwidthKhz == 8'd175)
        // [RL1]
        else $error("bandwidth decode wrong");

    a_atten_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        attenHalfDb == {3'b000, gainCtrl_reg[4:0]})      // [RL4]
        else $error("attenuation decode wrong");

    a_supply_ro: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) |->
        supplyRpt_reg == $past(supplyVoltageReading))    // [RL5]
        else $error("supply report not tracking");

    a_pin1_uv: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(dirCtrl_reg[1]) && $past(func_reg[1][3:0]) == FN_SUPPLY
        |-> pinOut[1] == $past(pinSrc.supplyUndervoltageDetect)) // [RL12]
        else $error("pin 1 undervoltage not routed");

    a_pin0_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(dirCtrl_reg[0]) && $past(func_reg[0][3:0]) == FN_SUPPLY
        |-> pinOut[0] == $past(pinSrc.supplyDropDetect)) // [RL10]
        else $error("pin 0 drop detect not routed");

    a_bresp_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
        doWrite |=> s_axi_bvalid)
        else $error("write response missing");

    c_write_done: cover property (@(posedge sys_clk)
        s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
    c_read_supply: cover property (@(posedge sys_clk)
        s_axi_arvalid && s_axi_arready && rdIdx == IDX_SUPPLY_RPT);
    c_all_out: cover property (@(posedge sys_clk) pinOe == 3'b111);

endmodule : analog_and_pin_function_regs

// ==== design/amp_ctrl_pkg.sv ====
package amp_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register indices (offsets are word aligned: byte addr = 4*idx)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ANALOG_LOOP  = 8'h53;
    localparam logic [7:0] IDX_ANALOG_GAIN  = 8'h54;
    localparam logic [7:0] IDX_SUPPLY_RPT   = 8'h5E;
    localparam logic [7:0] IDX_PIN_DIR      = 8'h60;
    localparam logic [7:0] IDX_PIN0_FUNC    = 8'h61;
    localparam logic [7:0] IDX_PIN1_FUNC    = 8'h62;
    localparam logic [7:0] IDX_PIN2_FUNC    = 8'h63;
    localparam int         ADDR_W           = 10;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam int         BW_LSB           = 5;
    localparam int         PHASE_BIT        = 0;
    localparam logic [7:0] LOOP_MASK        = 8'h61;
    localparam logic [7:0] GAIN_MASK        = 8'h1F;
    localparam logic [7:0] DIR_MASK         = 8'h07;
    localparam logic [7:0] FUNC_MASK        = 8'h0F;
    localparam int         NUM_PINS         = 3;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BW_100K = 2'b00,
        BW_80K  = 2'b01,
        BW_120K = 2'b10,
        BW_175K = 2'b11
    } loop_bw_t;

    typedef enum logic [3:0] {
        FN_LOW     = 4'b0000,
        FN_WARN    = 4'b1000,
        FN_FAULT   = 4'b1011,
        FN_SUPPLY  = 4'b1100,
        FN_SDATA   = 4'b1101,
        FN_RAMPCLK = 4'b1110
    } pin_func_t;

    // Status signals that can be routed onto a pin
    typedef struct packed {
        logic warningOutN;
        logic faultOutN;
        logic supplyDropDetect;
        logic supplyUndervoltageDetect;
        logic serialAudioDataOut;
        logic rampClk;
    } pin_src_t;

    // Analog control outputs
    typedef struct packed {
        logic [1:0] loopBandwidthSel;
        logic       channelPhaseSel;
        logic [4:0] analogAttenuation;
    } analog_cfg_t;

endpackage : amp_ctrl_pkg

// ==== design/pin_func_mux.sv ====
`timescale 1ns/1ps
module pin_func_mux
    import amp_ctrl_pkg::*;
#(
    parameter bit USE_UV = 1'b0
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       outputEnable,
    input  wire logic [3:0] pinFunction,
    input  wire pin_src_t   src,
    output logic            pinOut,
    output logic            pinOe
);

    // ----------------------------------------------------------------
    // Function decode
    // ----------------------------------------------------------------
    logic muxVal;

    // Reserved codes fall back to low, a safe idle level
    always_comb begin
        unique case (pinFunction)
            FN_WARN:    muxVal = src.warningOutN;        // [RL9] [RL11] [RL13]
            FN_FAULT:   muxVal = src.faultOutN;          // [RL9] [RL11] [RL13]
            FN_SUPPLY:  muxVal = USE_UV ? src.supplyUndervoltageDetect
                                        : src.supplyDropDetect; // [RL10] [RL12] [RL14]
            FN_SDATA:   muxVal = src.serialAudioDataOut; // [RL10] [RL12] [RL14]
            FN_RAMPCLK: muxVal = src.rampClk;            // [RL10] [RL12] [RL14]
            default:    muxVal = 1'b0;                   // [RL15]
        endcase
    end

    // Registered pin drive, enabled only in output direction
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end else begin
            pinOut <= outputEnable ? muxVal : 1'b0;      // [RL16]
            pinOe  <= outputEnable;                      // [RL6] [RL7] [RL8]
        end
    end

    a_pin_undriven: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(outputEnable) |-> !pinOe && !pinOut)      // [RL16]
        else $error("pin driven while direction is input");

    a_pin_low_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(pinFunction) == FN_LOW |-> !pinOut)        // [RL15]
        else $error("pin not low for off function");

    a_pin_warn: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(outputEnable) && $past(pinFunction) == FN_WARN
        |-> pinOut == $past(src.warningOutN))            // [RL9]
        else $error("warning not routed to pin");

    a_pin_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(outputEnable) && $past(pinFunction) == FN_FAULT
        |-> pinOut == $past(src.faultOutN))              // [RL11]
        else $error("fault not routed to pin");

    a_pin_ramp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(outputEnable) && $past(pinFunction) == FN_RAMPCLK
        |-> pinOut == $past(src.rampClk))                // [RL14]
        else $error("ramp clock not routed to pin");

    c_pin_sdata: cover property (@(posedge sys_clk)
        pinOe && pinFunction == FN_SDATA);

endmodule : pin_func_mux

// ==== design/analog_decode.sv ====
`timescale 1ns/1ps
module analog_decode
    import amp_ctrl_pkg::*;
(
    input  wire logic [1:0]  loopBandwidthSel,
    input  wire logic [4:0]  analogAttenuation,
    output logic [7:0]       loopBandwidthKhz,
    output logic [7:0]       attenHalfDb
);

    // ----------------------------------------------------------------
    // Bandwidth code to kHz, attenuation code to 0.5 dB steps
    // ----------------------------------------------------------------
    always_comb begin
        unique case (loop_bw_t'(loopBandwidthSel))
            BW_100K: loopBandwidthKhz = 8'd100;          // [RL1]
            BW_80K:  loopBandwidthKhz = 8'd80;           // [RL1]
            BW_120K: loopBandwidthKhz = 8'd120;          // [RL1]
            BW_175K: loopBandwidthKhz = 8'd175;          // [RL1]
        endcase
    end

    // One code step is one half dB of attenuation
    assign attenHalfDb = {3'b000, analogAttenuation};    // [RL4]

endmodule : analog_decode

// ==== tb/analog_and_pin_function_regs_test.sv ====
`timescale 1ns/1ps
module analog_and_pin_function_regs_test
    import amp_ctrl_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic              sysClk      = 1'b0;
    logic              rstN        = 1'b0;
    logic [ADDR_W-1:0] awAddr      = '0;
    logic              awValid     = 1'b0;
    logic              awReady;
    logic [31:0]       wData       = 32'h0000_0000;
    logic [3:0]        wStrb       = 4'h1;
    logic              wValid      = 1'b0;
    logic              wReady;
    logic [1:0]        bResp;
    logic              bValid;
    logic              bReady      = 1'b0;
    logic [ADDR_W-1:0] arAddr      = '0;
    logic              arValid     = 1'b0;
    logic              arReady;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              rValid;
    logic              rReady      = 1'b0;
    logic [7:0]        supplyLevel = 8'h00;
    analog_cfg_t       analogCfg;
    logic [7:0]        bwKhz;
    logic [7:0]        halfDb;
    pin_src_t          pinSrc      = '0;
    logic [2:0]        pinIn       = 3'h5;
    logic [2:0]        pinOut;
    logic [2:0]        pinOe;
    int                nErrors     = 0;
    int                totalChecks = 0;

    // 40 MHz clock
    always #12.5 sysClk = ~sysClk;

    analog_and_pin_function_regs DUT (
        .sys_clk(sysClk), .rst_n(rstN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .supplyVoltageReading(supplyLevel), .analogCfg(analogCfg),
        .loopBandwidthKhz(bwKhz), .attenHalfDb(halfDb),
        .pinSrc(pinSrc), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
    );

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic giveVerdict();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : giveVerdict

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ------------------------------------------------------------
    // Bus master; ready sampled mid-cycle, inputs only move at posedge
    // ------------------------------------------------------------
    task automatic axiWrite(input logic [7:0] idx, input logic [31:0] data,
                            output logic [1:0] resp);
        logic awTake;
        logic wTake;
        logic done;
        awAddr  <= {idx, 2'b00};
        wData   <= data;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 20 && !done; n++) begin
            @(negedge sysClk);
            awTake = awValid && awReady;
            wTake  = wValid && wReady;
            done   = (bValid === 1'b1);
            resp   = bResp;
            @(posedge sysClk);
            if (awTake) awValid <= 1'b0;
            if (wTake) wValid <= 1'b0;
        end
        if (!done) begin
            check("write answer", 32'h0000_0000, 32'h0000_0001);
            giveVerdict();
        end
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
        logic arTake;
        logic done;
        arAddr  <= {idx, 2'b00};
        arValid <= 1'b1;
        rReady  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 20 && !done; n++) begin
            @(negedge sysClk);
            arTake = arValid && arReady;
            done   = (rValid === 1'b1);
            data   = rData;
            resp   = rResp;
            @(posedge sysClk);
            if (arTake) arValid <= 1'b0;
        end
        if (!done) begin
            check("read answer", 32'h0000_0000, 32'h0000_0001);
            giveVerdict();
        end
    endtask : axiRead

    // Shorthands expecting an OKAY answer
    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        logic [1:0] resp;
        axiWrite(idx, data, resp);
        check("write resp", resp, RESP_OKAY);
    endtask : wr

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] data;
        logic [1:0]  resp;
        axiRead(idx, data, resp);
        check("read resp", resp, RESP_OKAY);
        check("read data", data, exp);
    endtask : rdChk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic doReset();
        rstN <= 1'b0;
        repeat (6) @(posedge sysClk);
        rstN <= 1'b1;
        @(posedge sysClk);
    endtask : doReset

    // Every register reads zero and no pin is driven after reset
    task automatic testReset();
        logic [7:0] idxs [7] = '{IDX_ANALOG_LOOP, IDX_ANALOG_GAIN,
            IDX_SUPPLY_RPT, IDX_PIN_DIR, IDX_PIN0_FUNC, IDX_PIN1_FUNC,
            IDX_PIN2_FUNC};
        check("pinOe after reset", pinOe, 3'h0);
        for (int i = 0; i < 7; i++) rdChk(idxs[i], 32'h0000_0000);
    endtask : testReset

    // All bandwidth codes, phase toggled, reserved bits written as ones
    task automatic testLoop();
        logic [7:0] khz [4] = '{8'h64, 8'h50, 8'h78, 8'hAF};
        logic [1:0] bw;
        logic       ph;
        for (int b = 0; b < 4; b++) begin
            bw = b[1:0];
            ph = ~bw[0];
            wr(IDX_ANALOG_LOOP, {24'h00_0000, 1'b1, bw, 4'hF, ph});
            rdChk(IDX_ANALOG_LOOP, {24'h00_0000, 1'b0, bw, 4'h0, ph});
            check("bw sel", analogCfg.loopBandwidthSel, bw);
            check("bw khz", bwKhz, khz[b]);
            check("phase", analogCfg.channelPhaseSel, ph);
        end
    endtask : testLoop

    // Gain boundaries: 0 dB, one step, full 15.5 dB
    task automatic testGain();
        logic [4:0] codes [3] = '{5'h00, 5'h01, 5'h1F};
        for (int i = 0; i < 3; i++) begin
            wr(IDX_ANALOG_GAIN, {24'h00_0000, 3'h7, codes[i]});
            rdChk(IDX_ANALOG_GAIN, {27'h000_0000, codes[i]});
            check("atten", analogCfg.analogAttenuation, codes[i]);
            check("half dB", halfDb, {3'h0, codes[i]});
        end
    endtask : testGain

    // Report follows the input and ignores writes
    task automatic testSupply();
        supplyLevel <= 8'h64;
        repeat (2) @(posedge sysClk);
        wr(IDX_SUPPLY_RPT, 32'h0000_00FF);
        rdChk(IDX_SUPPLY_RPT, 32'h0000_0064);
        supplyLevel <= 8'hC8;
        repeat (2) @(posedge sysClk);
        rdChk(IDX_SUPPLY_RPT, 32'h0000_00C8);
    endtask : testSupply

    // Selected source at level lvl, every other source opposite; with no source selected, all at lvl
    function automatic pin_src_t mkSrc(input logic [3:0] code, input int p,
                                       input logic lvl);
        pin_src_t s;
        s = lvl ? '0 : '1;
        case (code)
            4'b1000: s.warningOutN = lvl;
            4'b1011: s.faultOutN = lvl;
            4'b1100: begin
                if (p == 1) s.supplyUndervoltageDetect = lvl;
                else s.supplyDropDetect = lvl;
            end
            4'b1101: s.serialAudioDataOut = lvl;
            4'b1110: s.rampClk = lvl;
            default: s = lvl ? '1 : '0;
        endcase
        return s;
    endfunction : mkSrc

    // Each pin, each code, both source levels; reserved code drives low
    task automatic testPins();
        logic [3:0] codes [7] = '{4'h0, 4'h8, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
        logic       lvl;
        for (int p = 0; p < 3; p++) begin
            wr(IDX_PIN_DIR, 32'h0000_0001 << p);
            for (int c = 0; c < 7; c++) begin
                wr(IDX_PIN0_FUNC + p[7:0], {28'h000_0000, codes[c]});
                for (int l = 0; l < 2; l++) begin
                    lvl = l[0];
                    pinSrc <= mkSrc(codes[c], p, lvl);
                    repeat (2) @(posedge sysClk);
                    check("pinOe", pinOe, 3'h1 << p);
                    check("pinOut", pinOut[p], (codes[c] inside {4'h0, 4'hF})
                        ? 1'b0 : lvl);
                end
            end
            // Back to input with a function still selected and high
            wr(IDX_PIN0_FUNC + p[7:0], 32'h0000_0008);
            pinSrc <= mkSrc(4'h8, p, 1'b1);
            wr(IDX_PIN_DIR, 32'h0000_00F8);
            repeat (2) @(posedge sysClk);
            rdChk(IDX_PIN_DIR, 32'h0000_0000);
            check("pinOe input", pinOe, 3'h0);
            check("pinOut input", pinOut, 3'h0);
        end
    endtask : testPins

    // Unmapped index answers with an error and zero data
    task automatic testUnmapped();
        logic [31:0] data;
        logic [1:0]  resp;
        axiWrite(8'h55, 32'h0000_00FF, resp);
        check("unmapped wr resp", resp, RESP_SLVERR);
        axiRead(8'h55, data, resp);
        check("unmapped rd resp", resp, RESP_SLVERR);
        check("unmapped rd data", data, 32'h0000_0000);
    endtask : testUnmapped

    // ------------------------------------------------------------
    // Main sequence; second reset in mid-run must clear everything
    // ------------------------------------------------------------
    initial begin
        doReset();
        testReset();
        testLoop();
        testGain();
        testSupply();
        testPins();
        testUnmapped();
        wr(IDX_PIN_DIR, 32'h0000_0007);
        supplyLevel <= 8'h00;
        doReset();
        testReset();
        giveVerdict();
    end

endmodule : analog_and_pin_function_regs_test
